// [sepa_pkg.sv]
/*
 * Shared constants of the serial EEPROM slave: opcodes, status bit
 * positions, array geometry and self-timed write length.
 * Assumes a single 125 MHz system clock.
 */
package sepa_pkg;

    // =====================================================================
    // Clock and timing
    localparam int CLK_FREQ_HZ = 125_000_000;
    localparam int WRITE_CYCLE_US = 10_000;
    localparam int WRITE_CYCLES = WRITE_CYCLE_US * (CLK_FREQ_HZ / 1_000_000);

    // =====================================================================
    // Array geometry
    localparam int ADDR_W = 11;
    localparam int PAGE_W = 5;
    localparam int PAGE_BYTES = 32;

    // =====================================================================
    // Opcodes, most significant bit first
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_STAT_READ = 8'h05;
    localparam logic [7:0] OP_STAT_WRITE = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;

    // =====================================================================
    // Status register layout, value read while busy and values after reset
    localparam int ST_PIN_EN_POS = 7;
    localparam int ST_GUARD1_POS = 3;
    localparam int ST_GUARD0_POS = 2;
    localparam int ST_LATCH_POS = 1;
    localparam int ST_WIP_POS = 0;
    localparam logic [7:0] STATUS_BUSY = 8'hff;
    localparam logic PIN_EN_RESET = 1'b0;
    localparam logic [1:0] GUARD_RESET = 2'h0;

    // =====================================================================
    // Transfer states
    typedef enum logic [3:0] {
        SEPA_IDLE, SEPA_OPCODE, SEPA_ADDR, SEPA_READ, SEPA_STATUS,
        SEPA_WDATA, SEPA_SDATA, SEPA_LATCH, SEPA_IGNORE
    } sepa_state_t;

endpackage : sepa_pkg

// [sepa_sync.sv]
/*
 * Two flip-flop synchroniser for a vector of asynchronous pins.
 * Assumes each bit is an independent level; no word coherence.
 */
`timescale 1ns/1ps
module sepa_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins and synchronised levels
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            synced <= '0;
        end else begin
            meta_q <= async;
            synced <= meta_q;
        end
    end

endmodule : sepa_sync

// [sepa_mem.sv]
/*
 * Byte array of the EEPROM with one registered read port and one
 * write port. Assumes contents are undefined until written.
 */
`timescale 1ns/1ps
module sepa_mem #(
    parameter int AW = 11
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] wAddr,
    input wire logic [7:0] wData,
    // Read port
    input wire logic [AW-1:0] rAddr,
    output logic [7:0] rData
);
    logic [7:0] cells [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (we) begin
            cells[wAddr] <= wData;
        end
        rData <= cells[rAddr];
    end

endmodule : sepa_mem

// [sepa_top.sv]
/*
 * Serial peripheral slave of a 2K x 8 EEPROM with write latch, block
 * guard and protect-pin protection, pause input and self-timed write.
 * Assumes all pins are asynchronous to clk and sampled by it; the link
 * clock is far slower than clk.
 */
`timescale 1ns/1ps

// Summary of operation
// RULE_01: Hardware protect active when protect pin low and pin enable is one.
// RULE_02: Protect inactive if pin high or enable zero; status then writable.
// RULE_03: Hardware protect blocks status writes and guarded array writes.
// RULE_04: Unguarded array stays writable whenever the write latch is set.
// RULE_05: Pin enable cannot be cleared while the protect pin stays low.
// RULE_06: Input sampled on rising clock, output changed on falling clock.
// RULE_07: Read sends opcode then 16 address bits; low 11 bits used.
// RULE_08: Read streams bytes, address increments, wraps top to zero.
// RULE_09: Chip select high ends any read.
// RULE_10: Status read opcode shifts status register out.
// RULE_11: Latch-set opcode needs deselect right after eight bits.
// RULE_12: Host array write holds select low, at least thirty-two clocks.
// RULE_13: Up to 32 bytes per page; address wraps within the page.
// RULE_14: Write starts only if select rises after a complete data byte.
// RULE_15: Host status write data has bits 0,1,4,5,6 zero.
// RULE_16: Status reads allowed during write; progress bit reads one.
// RULE_17: Pause input low suspends transfer, resumes at same point.
// RULE_18: Reset gives standby, output off, latch clear, needs select fall.
// RULE_19: Host waits after power-up before reads and writes.
// RULE_20: Write latch clears when any write cycle completes.
// RULE_21: Status bits: enable 7, guard 3 and 2, latch 1, progress 0.
// RULE_22: Guard code 01 top quarter, 10 top half, 11 all, 00 none.
// RULE_23: Opcodes 06, 04, 05, 01, 03, 02 decoded MSB first.
// RULE_24: Output driven only while shifting read data, off when paused.
// RULE_25: Writes to protected places leave contents unchanged.
module sepa_top
    import sepa_pkg::*;
#(
    parameter int WRITE_LEN = WRITE_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial link pins
    input wire logic sck,
    input wire logic csN,
    input wire logic si,
    input wire logic holdN,
    input wire logic wpN,
    output logic soOut,
    output logic soOe,
    // Status
    output logic writeBusy
);
    // =====================================================================
    // Pin synchronisation and edge detection
    logic [4:0] pinS;
    logic sckS, csS, siS, holdS, wpS;
    logic sckPrev_q, csPrev_q, armed_q;
    logic paused, sckRise, sckFall, csRise, csFall;

    sepa_sync #(.WIDTH(5)) pinSync (
        .clk(clk),
        .rst_n(rst_n),
        .async({sck, csN, si, holdN, wpN}),
        .synced(pinS)
    );
    assign {sckS, csS, siS, holdS, wpS} = pinS;

    // RULE_17 pause gates edges
    assign paused = ~holdS;
    assign csRise = csS & ~csPrev_q;
    // RULE_18 select fall needed
    assign csFall = ~csS & csPrev_q & armed_q;
    // RULE_06 rising samples, falling drives
    assign sckRise = sckS & ~sckPrev_q & ~csS & ~paused;
    assign sckFall = ~sckS & sckPrev_q & ~csS & ~paused;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sckPrev_q <= 1'b0;
            csPrev_q <= 1'b0;
            armed_q <= 1'b0;
        end else begin
            sckPrev_q <= sckS;
            csPrev_q <= csS;
            if (csS) begin
                armed_q <= 1'b1;
            end
        end
    end

    // =====================================================================
    // Status bits and protection
    logic pinEn_q, latch_q, busy_q;
    logic [1:0] guard_q;
    logic hwProt, arrayProt;
    logic [7:0] statusByte;
    logic [ADDR_W-1:0] addr_q;

    // RULE_01 protect when pin low
    // RULE_02 and enable set
    assign hwProt = ~wpS & pinEn_q;

    // RULE_22 guard ranges
    always_comb begin
        case (guard_q)
            2'h1: arrayProt = (addr_q[ADDR_W-1:ADDR_W-2] == 2'h3);
            2'h2: arrayProt = addr_q[ADDR_W-1];
            2'h3: arrayProt = 1'b1;
            default: arrayProt = 1'b0;
        endcase
    end

    // RULE_21 status layout
    // RULE_16 busy reads all ones
    always_comb begin
        statusByte = 8'h00;
        statusByte[ST_PIN_EN_POS] = pinEn_q;
        statusByte[ST_GUARD1_POS] = guard_q[1];
        statusByte[ST_GUARD0_POS] = guard_q[0];
        statusByte[ST_LATCH_POS] = latch_q;
        statusByte[ST_WIP_POS] = busy_q;
        if (busy_q) begin
            statusByte = STATUS_BUSY;
        end
    end

    // =====================================================================
    // Transfer state machine
    sepa_state_t state_q;
    logic [2:0] bitCnt_q, outBit_q;
    logic [7:0] shIn_q, newByte;
    logic byteAny_q, addrHi_q, driving_q;
    logic byteDone;

    assign newByte = {shIn_q[6:0], siS};
    assign byteDone = sckRise & (bitCnt_q == 3'h7);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= SEPA_IDLE;
            bitCnt_q <= 3'h0;
            outBit_q <= 3'h0;
            shIn_q <= 8'h00;
            byteAny_q <= 1'b0;
            addrHi_q <= 1'b0;
            driving_q <= 1'b0;
            addr_q <= '0;
        end else if (csS) begin
            // RULE_09 deselect ends transfer
            state_q <= SEPA_IDLE;
            driving_q <= 1'b0;
        end else if (csFall) begin
            state_q <= SEPA_OPCODE;
            bitCnt_q <= 3'h0;
            outBit_q <= 3'h0;
            byteAny_q <= 1'b0;
            addrHi_q <= 1'b0;
        end else begin
            if (sckRise) begin
                shIn_q <= newByte;
                bitCnt_q <= bitCnt_q + 3'h1;
            end
            case (state_q)
                SEPA_OPCODE: begin
                    // RULE_23 opcode decode
                    if (byteDone) begin
                        case (newByte)
                            OP_READ: state_q <= busy_q ? SEPA_IGNORE
                                                       : SEPA_ADDR;
                            OP_WRITE: state_q <= busy_q ? SEPA_IGNORE
                                                        : SEPA_ADDR;
                            OP_STAT_READ: state_q <= SEPA_STATUS;
                            OP_STAT_WRITE: state_q <= busy_q ? SEPA_IGNORE
                                                             : SEPA_SDATA;
                            OP_SET_LATCH: state_q <= busy_q ? SEPA_IGNORE
                                                            : SEPA_LATCH;
                            default: state_q <= SEPA_IGNORE;
                        endcase
                        addrHi_q <= (newByte == OP_READ);
                    end
                end
                SEPA_ADDR: begin
                    // RULE_07 keep low address bits
                    if (sckRise) begin
                        addr_q <= {addr_q[ADDR_W-2:0], siS};
                    end
                    if (byteDone) begin
                        byteAny_q <= 1'b1;
                        if (byteAny_q) begin
                            state_q <= addrHi_q ? SEPA_READ : SEPA_WDATA;
                            byteAny_q <= 1'b0;
                        end
                    end
                end
                SEPA_READ, SEPA_STATUS: begin
                    if (sckFall) begin
                        driving_q <= 1'b1;
                        outBit_q <= outBit_q + 3'h1;
                        // RULE_08 increment and wrap
                        if (outBit_q == 3'h7 && state_q == SEPA_READ) begin
                            addr_q <= addr_q + 1'b1;
                        end
                    end
                end
                SEPA_WDATA: begin
                    // RULE_13 wrap within page
                    if (byteDone) begin
                        byteAny_q <= 1'b1;
                        addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] + 1'b1;
                    end
                end
                SEPA_SDATA: begin
                    if (byteDone) begin
                        byteAny_q <= 1'b1;
                    end
                    if (sckRise && byteAny_q) begin
                        state_q <= SEPA_IGNORE;
                    end
                end
                SEPA_LATCH: begin
                    // RULE_11 extra clocks void the latch set
                    if (sckRise) begin
                        state_q <= SEPA_IGNORE;
                    end
                end
                SEPA_IDLE, SEPA_IGNORE: begin
                end
                default: state_q <= SEPA_IGNORE;
            endcase
        end
    end

    // =====================================================================
    // Page buffer
    logic [7:0] pageBuf_q [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] pageValid_q;
    logic [7:0] statPend_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pageValid_q <= '0;
            statPend_q <= 8'h00;
        end else if (csFall && !busy_q) begin
            // A status read during the write must not drop uncopied bytes
            pageValid_q <= '0;
        end else if (byteDone && state_q == SEPA_WDATA) begin
            pageBuf_q[addr_q[PAGE_W-1:0]] <= newByte;
            pageValid_q[addr_q[PAGE_W-1:0]] <= 1'b1;
        end else if (byteDone && state_q == SEPA_SDATA && !byteAny_q) begin
            statPend_q <= newByte;
        end
    end

    // =====================================================================
    // Write start decision and self-timed write
    logic startPage, startStat, pageMode_q;
    logic [ADDR_W-PAGE_W-1:0] pageBase_q;
    logic [31:0] wrCnt_q;
    logic memWe;
    logic [PAGE_W-1:0] wrIdx;

    // RULE_14 complete byte at deselect
    // RULE_04 unguarded needs only latch
    // RULE_25 guarded page stays untouched
    assign startPage = csRise && state_q == SEPA_WDATA && bitCnt_q == 3'h0
        && byteAny_q && latch_q && !arrayProt;
    // RULE_03 status blocked by protect
    // RULE_05 enable sticks while pin low
    assign startStat = csRise && state_q == SEPA_SDATA && bitCnt_q == 3'h0
        && byteAny_q && latch_q && !hwProt;

    assign wrIdx = wrCnt_q[PAGE_W-1:0];
    assign memWe = busy_q && pageMode_q && wrCnt_q < PAGE_BYTES
        && pageValid_q[wrIdx];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_q <= 1'b0;
            pageMode_q <= 1'b0;
            pageBase_q <= '0;
            wrCnt_q <= 32'h0;
        end else if (startPage || startStat) begin
            busy_q <= 1'b1;
            pageMode_q <= startPage;
            pageBase_q <= addr_q[ADDR_W-1:PAGE_W];
            wrCnt_q <= 32'h0;
        end else if (busy_q) begin
            wrCnt_q <= wrCnt_q + 32'h1;
            if (wrCnt_q == 32'(WRITE_LEN - 1)) begin
                busy_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinEn_q <= PIN_EN_RESET;
            guard_q <= GUARD_RESET;
        end else if (startStat) begin
            pinEn_q <= statPend_q[ST_PIN_EN_POS];
            guard_q <= {statPend_q[ST_GUARD1_POS], statPend_q[ST_GUARD0_POS]};
        end
    end

    // RULE_18 latch clear at reset
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            latch_q <= 1'b0;
        end else if (busy_q && wrCnt_q == 32'(WRITE_LEN - 1)) begin
            // RULE_20 clear on completion
            latch_q <= 1'b0;
        end else if (csRise && state_q == SEPA_LATCH) begin
            latch_q <= 1'b1;
        end else if (byteDone && state_q == SEPA_OPCODE && !busy_q
                     && newByte == OP_CLR_LATCH) begin
            latch_q <= 1'b0;
        end
    end

    // =====================================================================
    // Array and serial output
    logic [7:0] memRdata, outByte_q, curByte;

    sepa_mem #(.AW(ADDR_W)) array (
        .clk(clk),
        .we(memWe),
        .wAddr({pageBase_q, wrIdx}),
        .wData(pageBuf_q[wrIdx]),
        .rAddr(addr_q),
        .rData(memRdata)
    );

    // RULE_10 status shifted out
    always_comb begin
        curByte = outByte_q;
        if (outBit_q == 3'h0) begin
            curByte = (state_q == SEPA_STATUS) ? statusByte : memRdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            soOut <= 1'b1;
            soOe <= 1'b0;
            outByte_q <= 8'h00;
            writeBusy <= 1'b0;
        end else begin
            writeBusy <= busy_q;
            // RULE_24 drive only while shifting
            soOe <= ~csS & ~paused & driving_q;
            if (sckFall && (state_q == SEPA_READ
                            || state_q == SEPA_STATUS)) begin
                soOe <= 1'b1;
                soOut <= curByte[~outBit_q];
                outByte_q <= curByte;
            end
        end
    end

endmodule : sepa_top

// [sepa_top_sva.sv]
/*
 * Pin-level checker of the serial EEPROM slave.
 * Assumes binding to sepa_top, which hands on its WRITE_LEN.
 */
`timescale 1ns/1ps
module sepa_chk #(
    parameter int WRITE_LEN = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Link pins
    input wire logic sck,
    input wire logic csN,
    input wire logic si,
    input wire logic holdN,
    input wire logic wpN,
    input wire logic soOut,
    input wire logic soOe,
    // Status
    input wire logic writeBusy
);
    // =====================================================================
    // Busy length counter
    int busyCnt_q;
    always_ff @(posedge clk) begin
        if (!rst_n || !writeBusy) begin
            busyCnt_q <= 0;
        end else begin
            busyCnt_q <= busyCnt_q + 1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // =====================================================================
    // Sequences
    sequence deselected_s;
        csN [*5];
    endsequence
    sequence paused_s;
        !holdN [*5];
    endsequence
    sequence busyStart_s;
        $rose(writeBusy);
    endsequence

    // =====================================================================
    // Assertions
    desel_quiet_a: assert property (deselected_s |-> !soOe)
        else $error("so driven while deselected");
    pause_quiet_a: assert property (paused_s |-> !soOe)
        else $error("so driven while paused");
    oe_needs_sel_a: assert property ($rose(soOe) |-> !csN && holdN)
        else $error("so enabled without selection");
    so_edge_a: assert property (
        soOe && $changed(soOut) |-> !sck && !$past(sck, 2))
        else $error("so changed outside low clock phase");
    busy_start_a: assert property (
        busyStart_s |-> csN && $past(csN, 2))
        else $error("write started while selected");
    busy_hold_a: assert property (
        busyStart_s |=> writeBusy [*8])
        else $error("busy dropped early");
    busy_len_a: assert property (
        $fell(writeBusy) |-> busyCnt_q == WRITE_LEN)
        else $error("write cycle length wrong");
    reset_state_a: assert property (
        $rose(rst_n) |-> !soOe && !writeBusy && soOut)
        else $error("outputs not in standby after reset");
endmodule : sepa_chk

bind sepa_top sepa_chk #(.WRITE_LEN(WRITE_LEN)) sepa_chk_inst (
    .clk(clk), .rst_n(rst_n), .sck(sck), .csN(csN), .si(si),
    .holdN(holdN), .wpN(wpN), .soOut(soOut), .soOe(soOe),
    .writeBusy(writeBusy)
);

// [sepa_host.sv]
/*
 * Behavioural SPI host, mode 0, driving pins at falling clk edges.
 * Assumes one sck period of 20 clk cycles (160 ns at 125 MHz).
 */
`timescale 1ns/1ps
module sepa_host (
    // Clock
    input wire logic clk,
    // Link pins
    output logic sck,
    output logic csN,
    output logic si,
    output logic holdN,
    input wire logic soOut,
    input wire logic soOe,
    // Received byte toward the bench
    output logic [7:0] rxByte,
    output logic rxDone
);
    logic soLast;
    initial begin
        sck = 1'b0;
        csN = 1'b1;
        si = 1'b1;
        holdN = 1'b1;
        rxByte = 8'h00;
        rxDone = 1'b0;
        soLast = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic sel();
        tick(1);
        csN = 1'b0;
        tick(10);
    endtask : sel

    task automatic desel();
        tick(10);
        csN = 1'b1;
        si = ~si;
        tick(20);
    endtask : desel

    task automatic pause(input logic lvl);
        holdN = lvl;
        tick(8);
    endtask : pause

    // drive on fall, sample on rise
    task automatic xbits(input logic [7:0] tx, input int nb, input bit chk);
        logic [7:0] rx;
        rx = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            si = tx[i];
            tick(10);
            sck = 1'b1;
            soLast = soOe ? soOut : ~soLast;
            rx[i] = soLast;
            tick(10);
            sck = 1'b0;
        end
        if (chk) begin
            rxByte = rx;
            rxDone = 1'b1;
            tick(1);
            rxDone = 1'b0;
        end
    endtask : xbits
endmodule : sepa_host

// [sepa_top_bench.sv]
/*
 * Self-checking bench of sepa_top with the host model.
 * Assumes a shortened self-timed write of 1000 clk cycles.
 */
`timescale 1ns/1ps
module sepa_top_bench
    import sepa_pkg::*;
;
    logic clk, rst_n, wpN, sck, csN, si, holdN, soOut, soOe, writeBusy;
    logic rxDone;
    logic [7:0] rxByte;
    logic [7:0] img [0:2047];
    logic [7:0] expQ [$];
    logic [31:0] lfsr = 32'hd65f15ee;
    int n_fail = 0;
    int n_compared = 0;

    sepa_top #(.WRITE_LEN(1000)) sepa_top_inst (.clk(clk), .rst_n(rst_n),
        .sck(sck), .csN(csN), .si(si), .holdN(holdN), .wpN(wpN),
        .soOut(soOut), .soOe(soOe), .writeBusy(writeBusy));
    sepa_host sepa_host_inst (.clk(clk), .sck(sck), .csN(csN), .si(si),
        .holdN(holdN), .soOut(soOut), .soOe(soOe), .rxByte(rxByte),
        .rxDone(rxDone));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // =====================================================================
    // Checking and reporting
    function automatic logic [31:0] lfsrNext(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsrNext

    task automatic final_report();
        if (expQ.size() != 0) begin
            n_fail++;
        end
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    always @(posedge clk) begin
        if (rxDone === 1'b1) begin
            if (expQ.size() > 0) begin
                check(rxByte, expQ.pop_front());
            end else begin
                n_fail++;
                $display("MISMATCH t=%0t got=%h exp=none", $time, rxByte);
            end
        end
    end

    // =====================================================================
    // Transfers
    task automatic rd(input logic [7:0] exp);
        expQ.push_back(exp);
        sepa_host_inst.xbits(8'h00, 8, 1);
    endtask : rd

    task automatic cmd(input logic [7:0] op);
        sepa_host_inst.sel();
        sepa_host_inst.xbits(op, 8, 0);
        sepa_host_inst.desel();
    endtask : cmd

    task automatic statRd(input logic [7:0] exp);
        sepa_host_inst.sel();
        sepa_host_inst.xbits(OP_STAT_READ, 8, 0);
        rd(exp);
        sepa_host_inst.desel();
    endtask : statRd

    task automatic waitIdle(input logic expBusy);
        int k;
        check({7'h00, writeBusy}, {7'h00, expBusy});
        if (expBusy) begin
            statRd(8'hff);
            k = 0;
            while (writeBusy !== 1'b0 && k < 3000) begin
                sepa_host_inst.tick(1);
                k++;
            end
            if (k == 3000) begin
                n_fail++;
                final_report();
            end
        end
    endtask : waitIdle

    // Mode 0 plain, 1 no latch, 2 latch set in same selection, 3 extra bits
    task automatic wr(input logic [15:0] a, input int n, input int mode,
                      input logic expBusy);
        logic [4:0] off;
        if (mode == 0 || mode == 3) cmd(OP_SET_LATCH);
        sepa_host_inst.sel();
        if (mode == 2) sepa_host_inst.xbits(OP_SET_LATCH, 8, 0);
        sepa_host_inst.xbits(OP_WRITE, 8, 0);
        sepa_host_inst.xbits(a[15:8], 8, 0);
        sepa_host_inst.xbits(a[7:0], 8, 0);
        for (int i = 0; i < n; i++) begin
            lfsr = lfsrNext(lfsr);
            off = a[4:0] + 5'(i);
            sepa_host_inst.xbits(lfsr[7:0], 8, 0);
            if (expBusy) img[{a[10:5], off}] = lfsr[7:0];
        end
        if (mode == 3) sepa_host_inst.xbits(8'ha5, 3, 0);
        sepa_host_inst.desel();
        waitIdle(expBusy);
    endtask : wr

    task automatic wrStat(input logic [7:0] v, input logic expBusy);
        cmd(OP_SET_LATCH);
        sepa_host_inst.sel();
        sepa_host_inst.xbits(OP_STAT_WRITE, 8, 0);
        sepa_host_inst.xbits(v, 8, 0);
        sepa_host_inst.desel();
        waitIdle(expBusy);
    endtask : wrStat

    task automatic rdSeq(input logic [15:0] a, input int n, input bit hold);
        logic [10:0] p;
        p = a[10:0];
        sepa_host_inst.sel();
        sepa_host_inst.xbits(OP_READ, 8, 0);
        sepa_host_inst.xbits(a[15:8], 8, 0);
        sepa_host_inst.xbits(a[7:0], 8, 0);
        for (int i = 0; i < n; i++) begin
            if (hold && i == 1) begin
                sepa_host_inst.pause(1'b0);
                check({7'h00, soOe}, 8'h00);
                sepa_host_inst.pause(1'b1);
            end
            rd(img[p]);
            p = p + 11'h001;
        end
        sepa_host_inst.desel();
    endtask : rdSeq

    // =====================================================================
    // Main sequence
    initial begin
        logic [15:0] tgt;
        rst_n = 1'b0;
        wpN = 1'b1;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        sepa_host_inst.tick(10);
        check({6'h00, soOe, writeBusy}, 8'h00);
        statRd(8'h00);
        $display("test reset done");
        cmd(OP_SET_LATCH);
        statRd(8'h02);
        cmd(OP_CLR_LATCH);
        statRd(8'h00);
        wr(16'h0040, 1, 1, 0);
        wr(16'h0040, 1, 2, 0);
        wr(16'h0040, 1, 3, 0);
        statRd(8'h02);
        cmd(OP_CLR_LATCH);
        $display("test latch done");
        wr(16'h003e, 4, 0, 1);
        wr(16'hf7ff, 2, 0, 1);
        wr(16'h0000, 1, 0, 1);
        statRd(8'h00);
        rdSeq(16'h0020, 2, 0);
        rdSeq(16'h003e, 2, 0);
        $display("test page done");
        for (int c = 1; c < 4; c++) begin
            tgt = (c == 3) ? 16'h0000 : 16'h07ff;
            wrStat({4'h0, 2'(c), 2'b00}, 1);
            statRd({4'h0, 2'(c), 2'b00});
            wr(tgt, 1, 0, 0);
            if (c == 1) wr(16'h05ff, 1, 0, 1);
            if (c == 2) wr(16'h03ff, 1, 0, 1);
            cmd(OP_CLR_LATCH);
        end
        $display("test guard done");
        wrStat(8'h84, 1);
        @(negedge clk) wpN = 1'b0;
        wrStat(8'h00, 0);
        statRd(8'h86);
        cmd(OP_CLR_LATCH);
        wr(16'h0100, 1, 0, 1);
        @(negedge clk) wpN = 1'b1;
        wrStat(8'h00, 1);
        statRd(8'h00);
        $display("test protect done");
        rdSeq(16'hf7ff, 2, 1);
        rdSeq(16'h0100, 1, 0);
        rdSeq(16'h05ff, 1, 0);
        rdSeq(16'h03ff, 1, 0);
        $display("test pause done");
        final_report();
    end
endmodule : sepa_top_bench
